// ==== hdl/dusa_arbiter.sv ====
// Purpose: unit select arbiter for one or two controller channels
// Assumes: link pins synchronous to clk_sys_i; channel 0 only in single mode
// Notes: control and status reached over APB, one wait-free access phase
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dusa_arbiter
    import dusa_pkg::*;
#(
    parameter int TIMEOUT_CYC_P = TIMEOUT_CYC,
    parameter int DONE_LG_CYC_P = DONE_LG_CYC,
    parameter int DONE_SM_CYC_P = DONE_SM_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic plug_fitted_i,
    input wire logic [2:0] plug_addr_i,
    input wire logic index_i,
    input wire logic sector_i,
    input wire dusa_link_in_s [1:0] link_i,
    output dusa_link_out_s [1:0] link_o
);
    localparam int TW = 27;
    localparam int DW = 16;
    localparam int RW = 8;

    initial begin
        if (TIMEOUT_CYC_P < 1 || TIMEOUT_CYC_P >= 2**TW) $error("timeout count out of range");
        if (DONE_LG_CYC_P < 1 || DONE_LG_CYC_P >= 2**DW) $error("done count out of range");
        if (DONE_SM_CYC_P < 1 || DONE_SM_CYC_P >= 2**DW) $error("done count out of range");
    end

    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] res;
        logic [1:0] dis;
        logic [1:0] pend;
        logic alt;
        logic [CTRL_W-1:0] ctrl;
        logic [2:0] own;
        dusa_link_out_s [1:0] lo;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dusa_state_s;

    localparam dusa_link_out_s LO_RST = '{done_n: 1'b1, default: 1'b0};
    localparam dusa_state_s S_RST = '{
        ctrl: CTRL_RST,
        own: DEFAULT_ADDR,
        lo: {LO_RST, LO_RST},
        default: '0
    };

    dusa_state_s s_q, s_d;

    logic dual;
    logic [1:0] match, off, held_o, take, slot, rel;
    logic [1:0] res_start, res_done, done_start, done_active;
    logic tmo_start, tmo_done;
    logic [RW-1:0] res_len;
    logic [DW-1:0] done_len;

    assign dual = s_q.ctrl[CTRL_DUAL];
    assign res_len = s_q.ctrl[CTRL_LARGE] ? RW'(RES_LG_CYC) : RW'(RES_SM_CYC);
    assign done_len = s_q.ctrl[CTRL_LARGE] ? DW'(DONE_LG_CYC_P) : DW'(DONE_SM_CYC_P);

    // -------------------------------------------------------------
    // per-channel decode
    // -------------------------------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign match[c] = link_i[c].pick && link_i[c].cable
                          && !link_i[c].uaddr[UADDR_INHIBIT_BIT]
                          && (link_i[c].uaddr[2:0] == s_q.own)
                          && (dual || c == 0);
        assign off[c] = dual && (s_q.dis[c] || s_q.ctrl[CTRL_MAINT + c]);
        assign held_o[c] = dual && (s_q.sel[1 - c] || s_q.res[1 - c]);
        assign take[c] = dual && match[c] && !off[c] && link_i[c].bus9;
        // only one channel may set its selected flag per cycle
        assign slot[c] = dual ? (s_q.alt == 1'(c)) : 1'b1;
        // control strobe only heard while selected
        assign rel[c] = dual && s_q.sel[c] && link_i[c].ctl_strobe && link_i[c].bus9;
        assign res_start[c] = s_d.sel[c] && !s_q.sel[c];
        assign done_start[c] = s_q.pend[c] && !held_o[c];

        dusa_pulse #(.W(RW)) u_res (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .start_i(res_start[c]),
            .len_i(res_len),
            .active_o(),
            .done_o(res_done[c])
        );

        dusa_pulse #(.W(DW)) u_done (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .start_i(done_start[c]),
            .len_i(done_len),
            .active_o(done_active[c]),
            .done_o()
        );
    end

    // restarted by every deselection
    assign tmo_start = |(s_q.sel & ~s_d.sel);

    dusa_pulse #(.W(TW)) u_tmo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(tmo_start),
        .len_i(TW'(TIMEOUT_CYC_P)),
        .active_o(),
        .done_o(tmo_done)
    );

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.alt = !s_q.alt;
        // strap followed live so a plug change takes effect
        s_d.own = plug_fitted_i ? plug_addr_i : DEFAULT_ADDR;

        for (int c = 0; c < 2; c++) begin
            if (take[c] && slot[c]) begin
                s_d.sel[c] = 1'b1;
                s_d.dis[1 - c] = 1'b1;
                s_d.sel[1 - c] = 1'b0;
                s_d.res[1 - c] = 1'b0;
                s_d.pend[c] = 1'b0;
            end else if (match[c] && !off[c] && !held_o[c] && slot[c] && !s_q.sel[c]) begin
                s_d.sel[c] = 1'b1;
            end else if (s_q.sel[c] && (!match[c] || off[c])) begin
                s_d.sel[c] = 1'b0;
            end

            // a takeover by the other side outranks a reserve pulse ending now
            if (res_done[c] && s_q.sel[c] && !(take[1 - c] && slot[1 - c])) begin
                s_d.res[c] = 1'b1;
            end
            // only an idle reservation times out
            if (tmo_done && s_q.ctrl[CTRL_TMO] && !s_q.sel[c]) begin
                s_d.res[c] = 1'b0;
            end
            if (rel[c]) begin
                s_d.res[c] = 1'b0;
                s_d.dis[1 - c] = 1'b0;
                s_d.dis[c] = 1'b0;
            end

            // set wins over clear
            if (match[c] && !off[c] && held_o[c] && !take[c]) begin
                s_d.pend[c] = 1'b1;
            end else if (done_start[c]) begin
                s_d.pend[c] = 1'b0;
            end

            s_d.lo[c].busy = match[c] && !off[c] && held_o[c] && !take[c];
            s_d.lo[c].ack = (s_q.sel[c] && (s_q.res[c] || !dual) && !off[c]) || s_d.lo[c].busy;
            s_d.lo[c].if_en = s_q.sel[c] && !off[c];
            s_d.lo[c].done_n = !done_active[c];
            s_d.lo[c].index = (s_q.ctrl[CTRL_IDXB] || s_q.sel[c]) && index_i;
            s_d.lo[c].sector = (s_q.ctrl[CTRL_IDXB] || s_q.sel[c]) && sector_i;
        end

        // a release from the other side in the same cycle must not undo a takeover
        for (int c = 0; c < 2; c++) begin
            if (take[c] && slot[c] && !rel[c]) begin
                s_d.dis[1 - c] = 1'b1;
            end
        end

        // APB: data prepared in setup, pready raised for the access phase
        s_d.pready = psel_i && !penable_i;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (psel_i && !penable_i) begin
            if (paddr_i == CTRL_OFS) begin
                s_d.prdata = 32'(s_q.ctrl);
            end else if (paddr_i == STAT_OFS) begin
                s_d.prdata = 32'({s_q.alt, s_q.own, s_q.pend, s_q.dis, s_q.res, s_q.sel});
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
        if (psel_i && penable_i && s_q.pready && pwrite_i && paddr_i == CTRL_OFS) begin
            s_d.ctrl = pwdata_i[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign link_o = s_q.lo;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_sel_rise;
        $rose(s_q.sel[0]);
    endsequence

    sequence s_res_rise;
        $rose(s_q.res[0]);
    endsequence

    property p_one_sel;
        !(s_q.sel[0] && s_q.sel[1]);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("both channels selected");

    property p_sel_cause;
        s_sel_rise |-> $past(match[0]) && !$past(off[0]);
    endproperty
    a_sel_cause: assert property (p_sel_cause) else $error("select without match");

    property p_addr3;
        link_i[0].uaddr[UADDR_INHIBIT_BIT] && !s_q.sel[0] |=> !s_q.sel[0];
    endproperty
    a_addr3: assert property (p_addr3) else $error("selected with bit 3 active");

    property p_res_pulse;
        s_res_rise |-> $past(res_done[0]) && $past(s_q.sel[0]);
    endproperty
    a_res_pulse: assert property (p_res_pulse) else $error("reserve without pulse");

    property p_busy_ack;
        link_o[0].busy |-> link_o[0].ack && !link_o[0].if_en;
    endproperty
    a_busy_ack: assert property (p_busy_ack) else $error("busy without acknowledge");

    property p_silent;
        off[0] && !s_q.sel[0] |=> !link_o[0].busy && !link_o[0].ack;
    endproperty
    a_silent: assert property (p_silent) else $error("disabled channel answered");

    property p_done_low;
        $fell(s_q.pend[0]) && !$past(take[0]) |=> !link_o[0].done_n;
    endproperty
    a_done_low: assert property (p_done_low) else $error("no done pulse");

    property p_release;
        rel[0] |=> !s_q.res[0] && !s_q.dis[1];
    endproperty
    a_release: assert property (p_release) else $error("release ignored");

    property p_takeover;
        take[1] && slot[1] && !rel[1] |=> s_q.dis[0] && !s_q.sel[0] ##1 !link_o[0].if_en;
    endproperty
    a_takeover: assert property (p_takeover) else $error("takeover failed");

    property p_abs_hold;
        !s_q.ctrl[CTRL_TMO] && s_q.res[0] && !rel[0] && !take[1] |=> s_q.res[0];
    endproperty
    a_abs_hold: assert property (p_abs_hold) else $error("absolute hold lost");

    property p_idle_cut;
        !s_q.sel[0] |=> !link_o[0].if_en;
    endproperty
    a_idle_cut: assert property (p_idle_cut) else $error("link enabled unselected");

    property p_idle_cut_1;
        !s_q.sel[1] |=> !link_o[1].if_en;
    endproperty
    a_idle_cut_1: assert property (p_idle_cut_1) else $error("link 1 enabled unselected");

    property p_silent_1;
        off[1] && !s_q.sel[1] |=> !link_o[1].busy && !link_o[1].ack;
    endproperty
    a_silent_1: assert property (p_silent_1) else $error("disabled channel 1 answered");

    property p_done_low_1;
        $fell(s_q.pend[1]) && !$past(take[1]) |=> !link_o[1].done_n;
    endproperty
    a_done_low_1: assert property (p_done_low_1) else $error("no done pulse on channel 1");

    property p_takeover_0;
        take[0] && slot[0] && !rel[0] |=> s_q.dis[1] && !s_q.sel[1] ##1 !link_o[1].if_en;
    endproperty
    a_takeover_0: assert property (p_takeover_0) else $error("takeover by channel 0 failed");

    property p_abs_hold_1;
        !s_q.ctrl[CTRL_TMO] && s_q.res[1] && !rel[1] && !take[0] |=> s_q.res[1];
    endproperty
    a_abs_hold_1: assert property (p_abs_hold_1) else $error("absolute hold lost on channel 1");

    property p_ack_ready;
        dual && s_q.sel[0] && s_q.res[0] && !off[0] |=> link_o[0].ack;
    endproperty
    a_ack_ready: assert property (p_ack_ready) else $error("no acknowledge when held");

    property p_deselect;
        s_q.sel[0] && !match[0] |=> !s_q.sel[0];
    endproperty
    a_deselect: assert property (p_deselect) else $error("selection outlived strobe");

    property p_idx_b;
        s_q.ctrl[CTRL_IDXB] && index_i |=> link_o[0].index;
    endproperty
    a_idx_b: assert property (p_idx_b) else $error("index not passed with jumper B");

    property p_own_addr;
        !plug_fitted_i |=> s_q.own == DEFAULT_ADDR;
    endproperty
    a_own_addr: assert property (p_own_addr) else $error("default address not used");

    property p_single;
        !dual && match[0] |=> s_q.sel[0];
    endproperty
    a_single: assert property (p_single) else $error("single channel match not selected");
endmodule
`default_nettype wire

// ==== hdl/dusa_pkg.sv ====
// Purpose: shared constants and carriers of the drive unit select arbiter
// Assumes: clk_sys_i at 250 MHz, APB register access
// Notes: times stay in their own unit, cycle counts derive from the clock rate
//
// Overview of operation
// - link receivers and drivers off until selected
// - own address from plug, seven when absent
// - match needs equal address and cable present
// - single channel: match enables link, acknowledges
// - attempt fails if other holds or channel disabled
// - timeout mode releases 500 ms after deselect
// - takeover disables other channel, selects requester
// - maintenance switch disables its channel in dual mode
// - match selects, reserve pulse sets reserved flag
// - selected and reserved give unit acknowledged
// - strobe drop or address change deselects
// - reservation outlives deselection until released
// - blocked requester gets acknowledge plus busy
// - pending attempt clears into positioning-done low pulse
// - disabled channel gets no acknowledge, busy or link enable
// - alternation clock keeps selections mutually exclusive
// - jumper B drives index and sector always
// - control strobe with bit 9 releases reservation
// - address bit 3 must be inactive
// - disable flag stays until other channel releases
package dusa_pkg;
    localparam int CLK_MHZ = 250;
    localparam int RES_PULSE_LG_NS = 400;
    localparam int RES_PULSE_SM_NS = 300;
    localparam int DONE_PULSE_LG_US = 40;
    localparam int DONE_PULSE_SM_US = 30;
    localparam int HOLD_TIMEOUT_MS = 500;
    localparam int RES_LG_CYC = RES_PULSE_LG_NS * CLK_MHZ / 1000;
    localparam int RES_SM_CYC = RES_PULSE_SM_NS * CLK_MHZ / 1000;
    localparam int DONE_LG_CYC = DONE_PULSE_LG_US * CLK_MHZ;
    localparam int DONE_SM_CYC = DONE_PULSE_SM_US * CLK_MHZ;
    localparam int TIMEOUT_CYC = HOLD_TIMEOUT_MS * CLK_MHZ * 1000;

    localparam logic [2:0] DEFAULT_ADDR = 3'h7;
    localparam int UADDR_INHIBIT_BIT = 3;

    // register map
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam int CTRL_W = 6;
    localparam int CTRL_DUAL = 0;
    localparam int CTRL_TMO = 1;
    localparam int CTRL_LARGE = 2;
    localparam int CTRL_IDXB = 3;
    localparam int CTRL_MAINT = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h07;
    localparam int STAT_OWN = 8;
    localparam int STAT_ALT = 11;

    typedef struct packed {
        logic pick;
        logic ctl_strobe;
        logic bus9;
        logic cable;
        logic [3:0] uaddr;
    } dusa_link_in_s;

    typedef struct packed {
        logic ack;
        logic busy;
        logic if_en;
        logic done_n;
        logic index;
        logic sector;
    } dusa_link_out_s;
endpackage

// ==== hdl/dusa_pulse.sv ====
// Purpose: retriggerable one-shot counter for reserve, done and timeout pulses
// Assumes: len_i is at least one
// Notes: a start while running reloads the count
`timescale 1ns/1ps
`default_nettype none
module dusa_pulse
    import dusa_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [W-1:0] len_i,
    output logic active_o,
    output logic done_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } dusa_pulse_s;

    dusa_pulse_s s_q, s_d;

    initial begin
        if (W < 1) $error("dusa_pulse: width must be positive");
    end

    always_comb begin
        s_d = s_q;
        s_d.done = (s_q.cnt == W'(1)) && !start_i;
        if (start_i) begin
            s_d.cnt = len_i;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign active_o = (s_q.cnt != '0);
    assign done_o = s_q.done;
endmodule
`default_nettype wire

// ==== testbench/dusa_ctrl_model.sv ====
// Purpose: controller on one channel cable of the select arbiter
// Assumes: bench requests arrive as levels changed after a clock edge
// Notes: unit lines show the inverted address while the pick strobe is low
`timescale 1ns/1ps
`default_nettype none
module dusa_ctrl_model
    import dusa_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic pick_i,
    input wire logic [3:0] addr_i,
    input wire logic bus9_i,
    input wire logic rel_i,
    input wire logic cable_i,
    output var dusa_link_in_s link_o
);
    always @(posedge clk_sys_i) begin
        link_o.pick <= pick_i;
        // released lines must not look like a held address
        link_o.uaddr <= pick_i ? addr_i : ~addr_i;
        link_o.bus9 <= bus9_i | rel_i;
        link_o.ctl_strobe <= rel_i;
        link_o.cable <= cable_i;
    end
endmodule
`default_nettype wire

// ==== testbench/tb_dusa_arbiter.sv ====
// Purpose: self-checking bench of the unit select arbiter
// Assumes: short timeout 200 and done pulse 20 cycles
// Notes: register reads over APB, link driven by two controller models
`timescale 1ns/1ps
`default_nettype none
module tb_dusa_arbiter;
    import dusa_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prdata, q;
    logic plug_fit = 0, idx = 0, e;
    logic [2:0] plug_a = '0;
    logic [1:0] pk = '0, b9 = '0, rl = '0, cb = 2'h3;
    logic [3:0] ad [2] = '{4'h0, 4'h0};
    wire dusa_link_in_s [1:0] li;
    dusa_link_out_s [1:0] lo;
    int fail_count = 0, check_count = 0, n;
    initial forever #2 clk = ~clk;
    for (genvar c = 0; c < 2; c++) begin : g_ch
        dusa_ctrl_model i_dusa_ctrl_model (.clk_sys_i(clk), .pick_i(pk[c]), .addr_i(ad[c]),
            .bus9_i(b9[c]), .rel_i(rl[c]), .cable_i(cb[c]), .link_o(li[c]));
    end
    dusa_arbiter #(.TIMEOUT_CYC_P(200), .DONE_LG_CYC_P(20), .DONE_SM_CYC_P(15)) i_dusa_arbiter (
        .clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .plug_fitted_i(plug_fit), .plug_addr_i(plug_a), .index_i(idx), .sector_i(1'b0),
        .link_i(li), .link_o(lo));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            fail_count++;
            end_sim();
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        pen <= 0;
        // idle edge: a following call never reassigns psel in the same step
        @(posedge clk);
    endtask
    // bounded wait on a channel's unit acknowledged level
    task automatic wt(input int c, input logic v);
        int k;
        k = 0;
        while (lo[c].ack !== v && k < 400) begin
            @(posedge clk);
            k++;
        end
        chk(k < 400, 1);
        if (k >= 400) begin
            end_sim();
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        cyc(20);
        rst_n <= 1;
        cyc(2);
        apb(0, CTRL_OFS, 0); chk(q, 32'h07);
        apb(0, STAT_OFS, 0); chk(q[10:8], 3'h7);
        apb(0, 12'h010, 0); chk(e, 1);
        chk(lo[0].if_en, 0);
        idx <= 1;
        apb(1, CTRL_OFS, 32'h0F);
        cyc(3); chk(lo[0].index, 1);
        plug_fit <= 1;
        plug_a <= 3'h3;
        cyc(2);
        apb(0, STAT_OFS, 0); chk(q[10:8], 3'h3);
        ad[0] <= 4'hB;
        pk[0] <= 1;
        cyc(150); chk(lo[0].ack, 0);
        ad[0] <= 4'h3;
        cb[0] <= 0;
        cyc(150); chk(lo[0].ack, 0);
        cb[0] <= 1;
        wt(0, 1); chk({lo[0].busy, lo[0].if_en}, 2'b01);
        apb(0, STAT_OFS, 0); chk(q[3:0], 4'h5);
        pk[1] <= 1;
        ad[1] <= 4'h3;
        wt(1, 1); chk({lo[1].busy, lo[1].if_en}, 2'b10);
        apb(0, STAT_OFS, 0); chk(q[7:6], 2'b10);
        pk[0] <= 0;
        wt(0, 0); chk(lo[0].if_en, 0);
        apb(0, STAT_OFS, 0); chk(q[2], 1);
        n = 0;
        while (lo[1].done_n !== 1'b0 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 190 && n < 600, 1);
        if (n >= 600) begin
            end_sim();
        end
        n = 0;
        while (lo[1].done_n === 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(n, 20);
        if (n >= 100) begin
            end_sim();
        end
        wt(1, 1); chk(lo[1].busy, 0);
        b9[0] <= 1;
        pk[0] <= 1;
        wt(0, 1);
        b9[0] <= 0;
        apb(0, STAT_OFS, 0); chk(q[5:4], 2'b10);
        cyc(5); chk({lo[1].ack, lo[1].busy}, 2'b00);
        rl[0] <= 1;
        cyc(1);
        rl[0] <= 0;
        cyc(5);
        apb(0, STAT_OFS, 0); chk(q[5:2], 4'h0);
        pk[0] <= 0;
        apb(1, CTRL_OFS, 32'h2F);
        cyc(300); chk({lo[1].ack, lo[1].busy}, 2'b00);
        apb(1, CTRL_OFS, 32'h0F);
        wt(1, 1); chk(lo[1].busy, 0);
        apb(1, CTRL_OFS, 32'h0D);
        pk[1] <= 0;
        cyc(300);
        apb(0, STAT_OFS, 0); chk(q[3], 1);
        apb(1, CTRL_OFS, 32'h0E);
        pk[0] <= 1;
        wt(0, 1); chk(lo[0].if_en, 1);
        end_sim();
    end
    initial begin
        cyc(100000);
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
